// ---- rtc_chain_pkg.sv ----
// Constants and types shared by the real time clock divider chain.
// Assumes a single clock domain; no timing constants are needed.
package rtc_chain_pkg;

    // ****************************************************************
    // Chain geometry
    // ****************************************************************
    localparam int NUM_STAGES = 5;
    localparam int CHAIN_WIDTH = 48;
    localparam int PRESCALE_WIDTH = 16;
    localparam int COUNT_WIDTH = 32;
    localparam int HALF_WIDTH = 16;
    // Stage 0 is the prescale timer, stages 1..4 form the count block
    localparam int STAGE_WIDTH [NUM_STAGES] = '{16, 10, 6, 6, 10};
    localparam int STAGE_LSB [NUM_STAGES] = '{0, 16, 26, 32, 38};

    // ****************************************************************
    // Fixed dividers
    // ****************************************************************
    localparam int DIV_A_RATIO = 32;
    localparam int DIV_A_WIDTH = 5;
    localparam int DIV_B_RATIO = 8;
    localparam int DIV_B_WIDTH = 3;

    // ****************************************************************
    // Reset values (applied by power reset only)
    // ****************************************************************
    localparam logic [DIV_A_WIDTH-1:0] DIV_A_RESET = 5'h00;
    localparam logic [DIV_B_WIDTH-1:0] DIV_B_RESET = 3'h0;
    localparam logic [NUM_STAGES-1:0] REQ_RESET = 5'h00;

    // Clock source and divider selection
    typedef struct packed {
        logic ext_sel;
        logic div32_on;
        logic div8_on;
    } chain_cfg_type;

endpackage : rtc_chain_pkg

// ---- rtc_divider_chain.sv ----
// Real time clock: source select, two optional fixed dividers, a
// reloadable prescale timer and a four-stage reloadable count block.
// Assumes srst is the power reset; no other reset reaches this block.
// How it works
// RULE1 - Counting clock is internal every cycle or rising edges of a pin.
// RULE2 - Divide-by-32 and divide-by-8 stages head the chain, each bypassable.
// RULE3 - A reloadable 16-bit prescale timer clocks the count block.
// RULE4 - 32-bit count block of 10, 6, 6, 10 bit stages, two words.
// RULE5 - Every stage counts upward only.
// RULE6 - Each stage raises its own request when it wraps.
// RULE7 - All enabled requests merge onto one interrupt node output.
// RULE8 - Only the power reset clears the clock's state.
// RULE9 - Prescale timer and count block read together as one 48-bit timer.
// RULE10 - On wrap a stage reloads, advances the next, and requests.
// RULE11 - Alarm request when the count reaches a programmed time.
`timescale 1ns/1ps
`default_nettype none

module rtc_divider_chain
    import rtc_chain_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire chain_cfg_type cfg,
    input wire logic ext_clk_in,
    input wire logic prescale_wr,
    input wire logic [PRESCALE_WIDTH-1:0] prescale_wdata,
    input wire logic count_low_wr,
    input wire logic count_high_wr,
    input wire logic [HALF_WIDTH-1:0] count_wdata,
    input wire logic [CHAIN_WIDTH-1:0] reload_value,
    input wire logic [NUM_STAGES-1:0] irq_enable,
    input wire logic alarm_enable,
    input wire logic [COUNT_WIDTH-1:0] alarm_time,
    output logic [PRESCALE_WIDTH-1:0] prescale_reload_timer,
    output logic [HALF_WIDTH-1:0] count_low_word,
    output logic [HALF_WIDTH-1:0] count_high_word,
    output logic [CHAIN_WIDTH-1:0] timer48,
    output logic [NUM_STAGES-1:0] stage_req,
    output logic alarm_req,
    output logic irq_node
);

    // ****************************************************************
    // Clock source and fixed dividers
    // ****************************************************************
    logic ext_prev_q;
    logic [DIV_A_WIDTH-1:0] div_a_q;
    logic [DIV_B_WIDTH-1:0] div_b_q;
    logic [DIV_A_WIDTH-1:0] div_a_d;
    logic [DIV_B_WIDTH-1:0] div_b_d;

    wire src_tick = cfg.ext_sel ? (ext_clk_in && !ext_prev_q) : 1'b1; // RULE1
    wire div_a_tick = src_tick && (div_a_q == DIV_A_WIDTH'(DIV_A_RATIO - 1));
    wire after_a = cfg.div32_on ? div_a_tick : src_tick; // RULE2
    wire div_b_tick = after_a && (div_b_q == DIV_B_WIDTH'(DIV_B_RATIO - 1));
    wire chain_tick = cfg.div8_on ? div_b_tick : after_a; // RULE2

    assign div_a_d = (cfg.div32_on && src_tick) ? div_a_q + 1'b1 : div_a_q;
    assign div_b_d = (cfg.div8_on && after_a) ? div_b_q + 1'b1 : div_b_q;

    always_ff @(posedge clk) begin
        if (srst) begin // RULE8
            ext_prev_q <= 1'b0;
            div_a_q <= DIV_A_RESET;
            div_b_q <= DIV_B_RESET;
        end else begin
            ext_prev_q <= ext_clk_in;
            div_a_q <= div_a_d;
            div_b_q <= div_b_d;
        end
    end

    // ****************************************************************
    // Stage chain
    // ****************************************************************
    logic [NUM_STAGES-1:0] stage_tick;
    logic [NUM_STAGES-1:0] stage_wrap;
    logic [NUM_STAGES-1:0] stage_load;
    logic [CHAIN_WIDTH-1:0] load_value;
    logic [CHAIN_WIDTH-1:0] chain_q;

    assign load_value = {count_wdata, count_wdata[15:10], count_wdata[9:0],
                         prescale_wdata};
    // Low word loads stages 1 and 2, high word loads stages 3 and 4
    assign stage_load = {count_high_wr, count_high_wr, count_low_wr,
                         count_low_wr, prescale_wr};
    assign stage_tick = {stage_wrap[NUM_STAGES-2:0], chain_tick}; // RULE10

    genvar gi;
    generate
        for (gi = 0; gi < NUM_STAGES; gi++) begin : g_stage
            localparam int W = STAGE_WIDTH[gi];
            localparam int L = STAGE_LSB[gi];
            rtc_stage #(
                .WIDTH(W)
            ) u_stage (
                .clk(clk),
                .srst(srst),
                .tick(stage_tick[gi]), // RULE5
                .load(stage_load[gi]),
                .load_value(load_value[L +: W]),
                .reload_value(reload_value[L +: W]),
                .count_q(chain_q[L +: W]),
                .wrap(stage_wrap[gi]) // RULE10
            );
        end
    endgenerate

    // Count block split: bits 15:0 low word, 31:16 high word
    assign prescale_reload_timer = chain_q[15:0]; // RULE3
    assign count_low_word = chain_q[31:16]; // RULE4
    assign count_high_word = chain_q[47:32]; // RULE4
    assign timer48 = chain_q; // RULE9

    // ****************************************************************
    // Requests and alarm
    // ****************************************************************
    logic moved_q;
    logic [NUM_STAGES-1:0] req_q;
    logic alarm_q;
    logic node_q;

    wire [COUNT_WIDTH-1:0] count_now = chain_q[47:16];
    wire alarm_hit = alarm_enable && moved_q && (count_now == alarm_time);
    wire node_d = (|(stage_wrap & irq_enable)) || alarm_hit; // RULE7

    always_ff @(posedge clk) begin
        if (srst) begin // RULE8
            moved_q <= 1'b0;
            req_q <= REQ_RESET;
            alarm_q <= 1'b0;
            node_q <= 1'b0;
        end else begin
            moved_q <= stage_tick[1] || (|stage_load[4:1]);
            req_q <= stage_wrap; // RULE6
            alarm_q <= alarm_hit; // RULE11
            node_q <= node_d; // RULE7
        end
    end

    assign stage_req = req_q;
    assign alarm_req = alarm_q;
    assign irq_node = node_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    wire no_load = !(|stage_load);

    property p_prescale_inc;
        chain_tick && no_load && !stage_wrap[0] |=>
            prescale_reload_timer == $past(prescale_reload_timer) + 16'h0001;
    endproperty
    a_prescale_inc: assert property (p_prescale_inc) // RULE5
        else $error("prescale did not increment");

    property p_reload;
        stage_wrap[0] |=> prescale_reload_timer == $past(reload_value[15:0]);
    endproperty
    a_reload: assert property (p_reload) // RULE10
        else $error("prescale did not reload");

    property p_carry;
        stage_wrap[0] && no_load && !stage_wrap[1] |=>
            chain_q[25:16] == $past(chain_q[25:16]) + 10'h001;
    endproperty
    a_carry: assert property (p_carry) // RULE9
        else $error("first count stage missed carry");

    property p_stage_req;
        stage_wrap[3] |=> stage_req[3];
    endproperty
    a_stage_req: assert property (p_stage_req) // RULE6
        else $error("stage request missing after wrap");

    property p_stage_req_drop;
        !stage_wrap[3] |=> !stage_req[3];
    endproperty
    a_stage_req_drop: assert property (p_stage_req_drop) // RULE6
        else $error("stage request without wrap");

    property p_node;
        (|(stage_req & $past(irq_enable))) |-> irq_node;
    endproperty
    a_node: assert property (p_node) // RULE7
        else $error("interrupt node not raised");

    property p_node_quiet;
        !(|(stage_wrap & irq_enable)) && !alarm_hit |=> !irq_node;
    endproperty
    a_node_quiet: assert property (p_node_quiet) // RULE7
        else $error("interrupt node raised without request");

    property p_alarm;
        alarm_req |-> $past(count_now) == $past(alarm_time)
            && $past(alarm_enable);
    endproperty
    a_alarm: assert property (p_alarm) // RULE11
        else $error("alarm at wrong time");

    property p_internal;
        !cfg.ext_sel && !cfg.div32_on && !cfg.div8_on |-> chain_tick;
    endproperty
    a_internal: assert property (p_internal) // RULE1
        else $error("internal clock not passed");

    property p_div32;
        !cfg.ext_sel && cfg.div32_on && !cfg.div8_on && chain_tick
            ##1 $stable(cfg) |-> !chain_tick [*8];
    endproperty
    a_div32: assert property (p_div32) // RULE2
        else $error("divide-by-32 ticked early");

    property p_write_low;
        count_low_wr |=> count_low_word == $past(count_wdata);
    endproperty
    a_write_low: assert property (p_write_low) // RULE4
        else $error("low word write lost");

    c_full_wrap: cover property (stage_wrap[4]);
    c_alarm: cover property (alarm_req);
    c_node: cover property (irq_node);
    c_ext_tick: cover property (cfg.ext_sel && chain_tick);

endmodule : rtc_divider_chain

`default_nettype wire

// ---- rtc_divider_chain_tb.sv ----
// Self-checking bench for the real time clock divider chain.
// Assumes rtc_chain_pkg and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none

module rtc_divider_chain_tb
    import rtc_chain_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    chain_cfg_type cfg = 3'h4;
    logic ext_clk_in = 1'b0;
    logic prescale_wr = 1'b0;
    logic count_low_wr = 1'b0;
    logic count_high_wr = 1'b0;
    logic alarm_enable = 1'b0;
    logic [15:0] prescale_wdata = 16'h0000;
    logic [15:0] count_wdata = 16'h0000;
    logic [47:0] reload_value = 48'h0;
    logic [4:0] irq_enable = 5'h00;
    logic [31:0] alarm_time = 32'h0;
    logic [15:0] prescale_reload_timer, count_low_word, count_high_word, p0;
    logic [47:0] timer48;
    logic [4:0] stage_req;
    logic alarm_req, irq_node;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    int ratio [4] = '{1, 8, 32, 256};

    rtc_divider_chain u_dut (.clk(clk), .srst(srst), .cfg(cfg),
        .ext_clk_in(ext_clk_in), .prescale_wr(prescale_wr),
        .prescale_wdata(prescale_wdata), .count_low_wr(count_low_wr),
        .count_high_wr(count_high_wr), .count_wdata(count_wdata),
        .reload_value(reload_value), .irq_enable(irq_enable),
        .alarm_enable(alarm_enable), .alarm_time(alarm_time),
        .prescale_reload_timer(prescale_reload_timer),
        .count_low_word(count_low_word), .count_high_word(count_high_word),
        .timer48(timer48), .stage_req(stage_req), .alarm_req(alarm_req),
        .irq_node(irq_node));

    always #2 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            report_and_stop();
        end
    end

    task chk(input logic [47:0] seen, input logic [47:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task report_and_stop;
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    // Writes prescale and both count words with the source stopped
    task load(input logic [15:0] p, input logic [15:0] lo,
              input logic [15:0] hi);
        @(posedge clk);
        prescale_wr <= 1'b1;
        prescale_wdata <= p;
        count_low_wr <= 1'b1;
        count_wdata <= lo;
        @(posedge clk);
        prescale_wr <= 1'b0;
        count_low_wr <= 1'b0;
        count_high_wr <= 1'b1;
        count_wdata <= hi;
        @(posedge clk);
        count_high_wr <= 1'b0;
        #1;
        chk(timer48, {hi, lo, p});
    endtask : load

    // One rising edge on the external input; returns after it is taken
    task tick;
        @(posedge clk);
        ext_clk_in <= 1'b1;
        @(posedge clk);
        ext_clk_in <= 1'b0;
        #1;
    endtask : tick

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_reset;
        @(posedge clk);
        srst <= 1'b1;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk(timer48, 48'h0);
        chk({stage_req, alarm_req, irq_node}, 48'h0);
    endtask : t_reset

    task t_wrap;
        irq_enable <= 5'h01;
        reload_value <= 48'h0012;
        load(16'hFFFF, 16'h0000, 16'h0000);
        tick();
        chk(prescale_reload_timer, 48'h0012);
        chk(count_low_word, 48'h1);
        chk(stage_req, 48'h01);
        chk(irq_node, 48'h1);
        step(1);
        chk({stage_req, irq_node}, 48'h0);
        tick();
        chk(prescale_reload_timer, 48'h0013);
    endtask : t_wrap

    task t_ripple;
        irq_enable <= 5'h10;
        reload_value <= 48'hA5C3_96E1_0F0F;
        load(16'hFFFF, 16'hFFFF, 16'hFFFF);
        tick();
        chk(timer48, 48'hA5C3_96E1_0F0F);
        chk({count_high_word, count_low_word, prescale_reload_timer},
            48'hA5C3_96E1_0F0F);
        chk(stage_req, 48'h1F);
        chk(irq_node, 48'h1);
    endtask : t_ripple

    task t_alarm;
        irq_enable <= 5'h00;
        reload_value <= 48'h0;
        alarm_time <= 32'h0000_0006;
        alarm_enable <= 1'b1;
        load(16'hFFFF, 16'h0005, 16'h0000);
        tick();
        chk(count_low_word, 48'h6);
        chk({stage_req, alarm_req, irq_node}, 48'h04);
        step(1);
        chk({alarm_req, irq_node}, 48'h3);
        step(1);
        chk({alarm_req, irq_node}, 48'h0);
        alarm_enable <= 1'b0;
    endtask : t_alarm

    task t_divide;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            cfg <= i[2:0];
            step(2);
            p0 = prescale_reload_timer;
            step(512);
            chk(16'(prescale_reload_timer - p0), 512 / ratio[i]);
        end
    endtask : t_divide

    task t_ext;
        @(posedge clk);
        cfg <= 3'h4;
        step(2);
        p0 = prescale_reload_timer;
        repeat (5) tick();
        chk(16'(prescale_reload_timer - p0), 48'h5);
        @(posedge clk);
        ext_clk_in <= 1'b1;
        repeat (4) @(posedge clk);
        ext_clk_in <= 1'b0;
        step(1);
        chk(16'(prescale_reload_timer - p0), 48'h6);
    endtask : t_ext

    // Write and external tick on one edge: the write wins
    task t_collide;
        @(posedge clk);
        ext_clk_in <= 1'b1;
        prescale_wr <= 1'b1;
        prescale_wdata <= 16'h1234;
        @(posedge clk);
        ext_clk_in <= 1'b0;
        prescale_wr <= 1'b0;
        step(1);
        chk(prescale_reload_timer, 48'h1234);
    endtask : t_collide

    initial begin
        t_reset();
        t_wrap();
        t_ripple();
        t_alarm();
        t_divide();
        t_ext();
        t_collide();
        @(posedge clk);
        cfg <= 3'h0;
        step(20);
        t_reset();
        step(2);
        chk(prescale_reload_timer, 48'h2);
        report_and_stop();
    end
endmodule : rtc_divider_chain_tb

`default_nettype wire

// ---- rtc_stage.sv ----
// One reloadable up-counting stage of the divider chain.
// Assumes tick and load are synchronous one-cycle pulses on clk.
`timescale 1ns/1ps
`default_nettype none

module rtc_stage
    import rtc_chain_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic tick,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    input wire logic [WIDTH-1:0] reload_value,
    output logic [WIDTH-1:0] count_q,
    output logic wrap
);

    logic [WIDTH-1:0] count_d;
    wire at_max = &count_q;

    // A write wins over a carry arriving in the same cycle
    assign wrap = tick && at_max && !load;
    assign count_d = load ? load_value :
                     wrap ? reload_value :
                     tick ? count_q + 1'b1 : count_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

endmodule : rtc_stage

`default_nettype wire
